// ===== logic/sjle_core.sv
/*
 * Executes the skip, conditional-execute, computed jump and word load group
 * of a 16-bit instruction set against its own 32-entry register file.
 * Assumes a classic Wishbone master and a memory that answers reads with an ack.
 */
`timescale 1ns/1ps
module sjle_core (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire sjle_pkg::sjle_wb_req_type wb_req_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    output logic mem_req_out,
    output logic [31:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_rdata_in
);
    // ************************************************************
    // State
    // ************************************************************
    logic [31:0] regs_r [32];
    logic [31:0] instr_r;
    logic [11:0] prefix_r;
    logic [31:0] pc_r;
    sjle_pkg::sjle_flags_type flags_r;
    sjle_pkg::sjle_state_type state_r;
    logic [31:0] jtarget_r;
    logic delay_r;
    logic skip_r;
    logic loaded_r;
    logic [4:0] dest_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [31:0] pc_nxt;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire bus_take = wb_req_in.cyc & wb_req_in.stb & ~ack_r;
    wire bus_wr = bus_take & wb_req_in.we;
    wire [7:0] bus_adr = {wb_req_in.adr[7:2], 2'b00};
    wire hit_instr = bus_adr == sjle_pkg::INSTR_OFS;
    wire hit_prefix = bus_adr == sjle_pkg::PREFIX_OFS;
    wire hit_pc = bus_adr == sjle_pkg::PC_OFS;
    wire hit_flags = bus_adr == sjle_pkg::FLAGS_OFS;
    wire hit_ctrl = bus_adr == sjle_pkg::CTRL_OFS;
    wire hit_ldaddr = bus_adr == sjle_pkg::LDADDR_OFS;
    wire hit_regf = bus_adr[7] == sjle_pkg::REGF_BASE[7];
    wire [4:0] bus_idx = bus_adr[6:2];
    wire idle = state_r == sjle_pkg::ST_IDLE;
    wire start = bus_wr & hit_ctrl & wb_req_in.sel[0]
        & wb_req_in.dat[sjle_pkg::CTRL_START_BIT] & idle;
    wire [31:0] status_w = {28'h000_0000, loaded_r, delay_r, skip_r, ~idle};

    // ************************************************************
    // Instruction decode
    // ************************************************************
    wire [15:0] ins = instr_r[15:0];
    wire [15:0] next_hw = instr_r[31:16];
    wire [4:0] f_a = ins[4:0];
    wire [4:0] f_b = ins[9:5];
    wire [4:0] f_five_bit_immediate = ins[9:5];
    wire [3:0] f_cc = ins[3:0];
    wire [1:0] f_p = ins[11:10];
    wire pfx_valid = prefix_r[sjle_pkg::PFX_VALID_BIT];
    wire [10:0] pfx_k = prefix_r[10:0];
    wire dec_bset = ins[15:10] == sjle_pkg::OP_BIT_SET;
    wire dec_bclr = ins[15:10] == sjle_pkg::OP_BIT_CLEAR;
    wire dec_rz = ins[15:5] == sjle_pkg::OP_REG_ZERO;
    wire dec_rnz = ins[15:5] == sjle_pkg::OP_REG_NONZERO;
    wire dec_cond = ins[15:4] == sjle_pkg::OP_COND;
    wire dec_jump = ins[15:5] == sjle_pkg::OP_JUMP;
    wire dec_ld = ins[15:10] == sjle_pkg::OP_WORD_LOAD;
    wire dec_ldp = ins[15:12] == sjle_pkg::OP_BASE_LOAD;
    wire next_is_pfx = next_hw[15:11] == sjle_pkg::OP_PREFIX;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] word_align(input logic [31:0] a);
        return {a[31:2], 2'b00};
    endfunction

    // ************************************************************
    // Operands and outcomes
    // ************************************************************
    wire [4:0] bp_idx = {sjle_pkg::BP_INDEX_HIGH, f_p};
    wire [31:0] ra_val = regs_r[f_a];
    wire [31:0] rb_val = regs_r[f_b];
    wire [31:0] rp_val = regs_r[bp_idx];
    wire bit_val = ra_val[f_five_bit_immediate];
    wire cond_ok = sjle_pkg::cond_true(f_cc, flags_r);
    wire skip_w = (dec_bset & bit_val)
        | (dec_bclr & ~bit_val)
        | (dec_rz & (ra_val == 32'h0000_0000))
        | (dec_rnz & (ra_val != 32'h0000_0000))
        | (dec_cond & ~cond_ok);
    wire [31:0] skip_step = next_is_pfx ? sjle_pkg::STEP_SKIP_PFX : sjle_pkg::STEP_SKIP;
    wire [31:0] jump_to = {ra_val[30:0], 1'b0};
    wire [15:0] k16 = {pfx_k, f_five_bit_immediate};
    wire [31:0] ld_off = pfx_valid ? {{19{pfx_k[10]}}, pfx_k, 2'b00} : 32'h0000_0000;
    wire [31:0] ldp_off = pfx_valid ? {{14{k16[15]}}, k16, 2'b00}
        : {25'h000_0000, f_five_bit_immediate, 2'b00};
    wire [31:0] ld_addr = word_align(rb_val) + ld_off;
    wire [31:0] ldp_addr = word_align(rp_val) + ldp_off;
    wire is_load = dec_ld | dec_ldp;

    always_comb begin
        pc_nxt = pc_r + sjle_pkg::STEP_PLAIN;
        if (skip_w) begin
            pc_nxt = pc_r + skip_step;
        end
        if (delay_r) begin
            pc_nxt = jtarget_r;
        end
    end

    // ************************************************************
    // Bus answer
    // ************************************************************
    wire [31:0] rd_mux = hit_instr ? instr_r
        : hit_prefix ? {20'h0_0000, prefix_r}
        : hit_pc ? pc_r
        : hit_flags ? {28'h000_0000, flags_r}
        : hit_ctrl ? status_w
        : hit_ldaddr ? mem_addr_out
        : hit_regf ? regs_r[bus_idx]
        : 32'h0000_0000;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ack_r <= 1'b0;
            rdat_r <= sjle_pkg::RESET_WORD;
        end else begin
            ack_r <= bus_take;
            rdat_r <= bus_take ? rd_mux : rdat_r;
        end
    end
    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdat_r;

    // ************************************************************
    // Software-written registers
    // ************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            instr_r <= sjle_pkg::RESET_WORD;
            flags_r <= 4'h0;
        end else begin
            if (bus_wr & hit_instr & idle) begin
                instr_r <= sjle_pkg::merge_bytes(instr_r, wb_req_in.dat, wb_req_in.sel);
            end
            if (bus_wr & hit_flags & wb_req_in.sel[0]) begin
                flags_r <= wb_req_in.dat[3:0];
            end
        end
    end

    // ************************************************************
    // Execution and load sequencing
    // ************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_r <= sjle_pkg::ST_IDLE;
            pc_r <= sjle_pkg::RESET_WORD;
            prefix_r <= 12'h000;
            jtarget_r <= sjle_pkg::RESET_WORD;
            delay_r <= 1'b0;
            skip_r <= 1'b0;
            loaded_r <= 1'b0;
            dest_r <= 5'h00;
            mem_req_out <= 1'b0;
            mem_addr_out <= sjle_pkg::RESET_WORD;
        end else begin
            case (state_r)
                sjle_pkg::ST_IDLE: begin
                    if (start) begin
                        pc_r <= pc_nxt;
                        skip_r <= skip_w;
                        delay_r <= dec_jump & ~delay_r;
                        jtarget_r <= jump_to;
                        prefix_r <= 12'h000;
                        loaded_r <= 1'b0;
                        if (is_load) begin
                            state_r <= sjle_pkg::ST_LOAD;
                            mem_req_out <= 1'b1;
                            mem_addr_out <= dec_ldp ? ldp_addr : ld_addr;
                            dest_r <= f_a;
                        end
                    end else begin
                        if (bus_wr & hit_pc) begin
                            pc_r <= sjle_pkg::merge_bytes(pc_r, wb_req_in.dat, wb_req_in.sel);
                        end
                        if (bus_wr & hit_prefix) begin
                            prefix_r <= wb_req_in.dat[11:0];
                        end
                    end
                end
                sjle_pkg::ST_LOAD: begin
                    if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        loaded_r <= 1'b1;
                        state_r <= sjle_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= sjle_pkg::ST_IDLE;
                    mem_req_out <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    wire load_done = (state_r == sjle_pkg::ST_LOAD) & mem_ack_in;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 32; i++) begin
                regs_r[i] <= sjle_pkg::RESET_WORD;
            end
        end else if (load_done) begin
            regs_r[dest_r] <= mem_rdata_in;
        end else if (bus_wr & hit_regf) begin
            regs_r[bus_idx] <= sjle_pkg::merge_bytes(regs_r[bus_idx], wb_req_in.dat,
                wb_req_in.sel);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    wire plain_start = start & ~delay_r;

    bit_set_skip_a: assert property (
        plain_start & dec_bset |=> skip_r == $past(bit_val))
        else $error("bit set skip wrong");
    bit_clear_skip_a: assert property (
        plain_start & dec_bclr |=> skip_r == !$past(bit_val))
        else $error("bit clear skip wrong");
    skip_step_a: assert property (
        plain_start & skip_w |=> pc_r == $past(pc_r) + $past(skip_step))
        else $error("skip step wrong");
    reg_zero_a: assert property (
        plain_start & dec_rz & (ra_val == 32'h0000_0000) |=> skip_r)
        else $error("zero skip missed");
    reg_nonzero_a: assert property (
        plain_start & dec_rnz & (ra_val != 32'h0000_0000) |=> skip_r)
        else $error("nonzero skip wrong");
    cond_zero_a: assert property (
        plain_start & dec_cond & (f_cc == 4'h3) |=> skip_r == !$past(flags_r.z))
        else $error("zero condition wrong");
    cond_hi_a: assert property (
        plain_start & dec_cond & (f_cc == 4'hC) & (flags_r.c | flags_r.z) |=> skip_r)
        else $error("hi condition wrong");
    jump_target_a: assert property (
        plain_start & dec_jump |=> delay_r && jtarget_r[0] == 1'b0
            && jtarget_r[31:1] == $past(ra_val[30:0]))
        else $error("jump target wrong");
    delay_slot_a: assert property (
        start & delay_r |=> pc_r == $past(jtarget_r) && !delay_r)
        else $error("delay slot not honoured");
    load_align_a: assert property (
        mem_req_out |-> mem_addr_out[1:0] == 2'b00
            && ($stable(mem_addr_out) || $rose(mem_req_out)))
        else $error("load address unaligned");
    base_load_a: assert property (
        start & dec_ldp & ~pfx_valid |=> mem_addr_out
            == {$past(rp_val[31:2]), 2'b00} + {25'h000_0000, $past(f_five_bit_immediate), 2'b00})
        else $error("base load address wrong");
    flags_kept_a: assert property (
        !(bus_wr & hit_flags) |=> $stable(flags_r))
        else $error("flags changed");
    bit_top_a: assert property (
        plain_start & dec_bset & (f_five_bit_immediate == 5'h1F) |=> skip_r == $past(ra_val[31]))
        else $error("top bit skip wrong");
    cond_exec_a: assert property (
        plain_start & dec_cond & (f_cc == 4'h1) |=> skip_r == !$past(flags_r.c))
        else $error("carry condition wrong");
    cond_lt_a: assert property (
        plain_start & dec_cond & (f_cc == 4'h6)
            |=> skip_r == !($past(flags_r.n) ^ $past(flags_r.v)))
        else $error("lt condition wrong");
    cond_gt_a: assert property (
        plain_start & dec_cond & (f_cc == 4'h8)
            |=> skip_r == ($past(flags_r.z) | ($past(flags_r.n) ^ $past(flags_r.v))))
        else $error("gt condition wrong");
    jump_slot_a: assert property (
        plain_start & dec_jump |=> pc_r == $past(pc_r) + 32'h0000_0002)
        else $error("delay slot step wrong");
    load_pfx_a: assert property (
        start & dec_ld & pfx_valid |=> mem_addr_out == {$past(rb_val[31:2]), 2'b00}
            + {{19{$past(pfx_k[10])}}, $past(pfx_k), 2'b00})
        else $error("prefixed load address wrong");
    base_pfx_a: assert property (
        start & dec_ldp & pfx_valid |=> mem_addr_out
            == {$past(regs_r[{3'h4, f_p}][31:2]), 2'b00}
            + {{14{$past(pfx_k[10])}}, $past(pfx_k), $past(f_five_bit_immediate), 2'b00})
        else $error("prefixed base load wrong");
    load_write_a: assert property (
        load_done |=> regs_r[$past(dest_r)] == $past(mem_rdata_in))
        else $error("load data not written");
    mem_hold_a: assert property (
        mem_req_out & !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
        else $error("memory request dropped");
    group_flags_a: assert property (
        start |=> $stable(flags_r))
        else $error("flags changed by execute");
    ack_pulse_a: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (
        bus_take |=> wb_ack_out)
        else $error("bus request not acked");

    // ************************************************************
    // Covers
    // ************************************************************
    cover property (start & dec_ld & pfx_valid);
    cover property (plain_start & skip_w & next_is_pfx);
    cover property (start & dec_jump ##[1:20] start & delay_r);
    cover property (start & dec_ldp & pfx_valid ##[1:20] load_done);
    cover property (plain_start & dec_cond & cond_ok);
endmodule

// ===== shared/sjle_pkg.sv
/*
 * Constants, types and helpers for the skip, jump and load executor.
 * Assumes a classic Wishbone master with byte addresses and a 32-bit memory read port.
 */
package sjle_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] INSTR_OFS = 8'h00;
    localparam logic [7:0] PREFIX_OFS = 8'h04;
    localparam logic [7:0] PC_OFS = 8'h08;
    localparam logic [7:0] FLAGS_OFS = 8'h0C;
    localparam logic [7:0] CTRL_OFS = 8'h10;
    localparam logic [7:0] LDADDR_OFS = 8'h14;
    localparam logic [7:0] REGF_BASE = 8'h80;
    localparam int PFX_VALID_BIT = 11;
    localparam int CTRL_START_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SKIP_BIT = 1;
    localparam int ST_DELAY_BIT = 2;
    localparam int ST_LOADED_BIT = 3;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // ************************************************************
    // Instruction encodings
    // ************************************************************
    localparam logic [5:0] OP_BIT_SET = 6'h15;
    localparam logic [5:0] OP_BIT_CLEAR = 6'h14;
    localparam logic [5:0] OP_WORD_LOAD = 6'h16;
    localparam logic [3:0] OP_BASE_LOAD = 4'hB;
    localparam logic [10:0] OP_REG_ZERO = 11'h3F6;
    localparam logic [10:0] OP_REG_NONZERO = 11'h3FA;
    localparam logic [10:0] OP_JUMP = 11'h3FE;
    localparam logic [11:0] OP_COND = 12'h7F0;
    localparam logic [4:0] OP_PREFIX = 5'h13;
    localparam logic [2:0] BP_INDEX_HIGH = 3'h4;
    localparam logic [31:0] STEP_PLAIN = 32'h0000_0002;
    localparam logic [31:0] STEP_SKIP = 32'h0000_0004;
    localparam logic [31:0] STEP_SKIP_PFX = 32'h0000_0006;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {ST_IDLE, ST_LOAD} sjle_state_type;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sjle_wb_req_type;
    typedef struct packed {
        logic n;
        logic v;
        logic z;
        logic c;
    } sjle_flags_type;
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic cond_true(input logic [3:0] cc, input sjle_flags_type f);
        logic nv;
        nv = f.n ^ f.v;
        case (cc)
            4'h0: cond_true = ~f.c;
            4'h1: cond_true = f.c;
            4'h2: cond_true = ~f.z;
            4'h3: cond_true = f.z;
            4'h4: cond_true = ~f.n;
            4'h5: cond_true = f.n;
            4'h6: cond_true = nv;
            4'h7: cond_true = ~nv;
            4'h8: cond_true = ~(f.z | nv);
            4'h9: cond_true = f.z | nv;
            4'hA: cond_true = ~f.v;
            4'hB: cond_true = f.v;
            4'hC: cond_true = ~(f.c | f.z);
            4'hD: cond_true = f.c | f.z;
            default: cond_true = 1'b1;
        endcase
    endfunction
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge_bytes[8*i +: 8] = sel[i] ? new_w[8*i +: 8] : old_w[8*i +: 8];
        end
    endfunction
endpackage

// ===== bench/sjle_mem_model.sv
/*
 * Behavioural data memory answering the executor's load reads on its read port.
 * Assumes one read at a time; answers after delay_in idle cycles with addr xor DATA_MASK.
 */
`timescale 1ns/1ps
module sjle_mem_model #(
    parameter logic [31:0] DATA_MASK = 32'hC3C3_3C3C
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic mem_req_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [3:0] delay_in,
    output logic mem_ack_out,
    output logic [31:0] mem_rdata_out
);
    // ************************************************************
    // Read answer, data line toggles when not valid
    // ************************************************************
    logic [3:0] wait_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mem_ack_out <= 1'b0;
            mem_rdata_out <= 32'h5555_AAAA;
            wait_r <= 4'h0;
        end else if (mem_ack_out) begin
            mem_ack_out <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
            wait_r <= 4'h0;
        end else if (mem_req_in && wait_r >= delay_in) begin
            mem_ack_out <= 1'b1;
            mem_rdata_out <= mem_addr_in ^ DATA_MASK;
        end else begin
            mem_rdata_out <= ~mem_rdata_out;
            if (mem_req_in) begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// ===== bench/tb_top.sv
/*
 * Self-checking bench for the skip, jump and load executor.
 * Assumes the core's Wishbone register map and the memory model beside it.
 */
`timescale 1ns/1ps
module tb_top;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam logic [31:0] MEM_PAT = 32'hC3C3_3C3C;
    localparam logic [15:0] PFX_HW = {sjle_pkg::OP_PREFIX, 11'h000};
    logic sys_clk_in;
    logic sys_rst_in;
    sjle_pkg::sjle_wb_req_type wb_req;
    logic wb_ack, mem_req, mem_ack;
    logic [31:0] wb_dat, mem_addr, mem_rdata, rd;
    logic [3:0] mem_delay;
    int err_total = 0;
    int cmp_count = 0;
    sjle_core sjle_core_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .wb_req_in(wb_req), .wb_ack_out(wb_ack), .wb_dat_out(wb_dat),
        .mem_req_out(mem_req), .mem_addr_out(mem_addr), .mem_ack_in(mem_ack),
        .mem_rdata_in(mem_rdata));
    sjle_mem_model #(.DATA_MASK(MEM_PAT)) sjle_mem_model_i (.clk_in(sys_clk_in),
        .rst_in(sys_rst_in), .mem_req_in(mem_req), .mem_addr_in(mem_addr),
        .delay_in(mem_delay), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_dat;
        wb_req <= '0;
        if (n >= 20) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        wb_xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic run(input logic [31:0] ins);
        wr(sjle_pkg::INSTR_OFS, ins);
        wr(sjle_pkg::CTRL_OFS, 32'h0000_0001);
    endtask
    function automatic logic exp_cond(input logic [3:0] cc, input logic [3:0] f);
        logic n, v, z, c, x;
        logic [15:0] t;
        {n, v, z, c} = f;
        x = n ^ v;
        t = {2'b11, c | z, ~(c | z), v, ~v, z | x, ~(z | x), ~x, x, n, ~n, z, ~z, c, ~c};
        return t[cc];
    endfunction
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_bit_skip();
        logic [4:0] pos [5] = '{5'h00, 5'h05, 5'h1F, 5'h01, 5'h1E};
        logic [31:0] val;
        logic tk;
        val = 32'h8000_0021;
        wr(sjle_pkg::REGF_BASE + 8'h04, val);
        for (int p = 0; p < 5; p++) begin
            for (int op = 0; op < 2; op++) begin
                for (int nx = 0; nx < 2; nx++) begin
                    tk = (op == 0) ? val[pos[p]] : ~val[pos[p]];
                    wr(sjle_pkg::PC_OFS, 32'h0000_0100);
                    run({nx ? PFX_HW : 16'h0000,
                         op ? sjle_pkg::OP_BIT_CLEAR : sjle_pkg::OP_BIT_SET, pos[p], 5'h01});
                    rdr(sjle_pkg::PC_OFS);
                    check("bit skip pc", rd, 32'h0000_0100 + (tk ? (nx ? 6 : 4) : 2));
                    rdr(sjle_pkg::CTRL_OFS);
                    check("bit skip flag", rd[1], tk);
                end
            end
        end
    endtask
    task automatic t_reg_skip();
        wr(sjle_pkg::REGF_BASE + 8'h08, 32'h0000_0000);
        wr(sjle_pkg::REGF_BASE + 8'h0C, 32'h0001_0000);
        for (int op = 0; op < 2; op++) begin
            for (int r = 2; r < 4; r++) begin
                wr(sjle_pkg::PC_OFS, 32'h0000_0100);
                run({16'h0000, op ? sjle_pkg::OP_REG_NONZERO : sjle_pkg::OP_REG_ZERO, r[4:0]});
                rdr(sjle_pkg::PC_OFS);
                check("reg skip pc", rd, ((r == 2) != (op == 1)) ? 32'h104 : 32'h102);
            end
        end
    endtask
    task automatic t_cond();
        for (int f = 0; f < 16; f++) begin
            for (int cc = 0; cc < 16; cc++) begin
                wr(sjle_pkg::FLAGS_OFS, f);
                wr(sjle_pkg::PC_OFS, 32'h0000_0300);
                run({16'h0000, sjle_pkg::OP_COND, cc[3:0]});
                rdr(sjle_pkg::PC_OFS);
                check("cond pc", rd, exp_cond(cc[3:0], f[3:0]) ? 32'h302 : 32'h304);
                rdr(sjle_pkg::FLAGS_OFS);
                check("flags kept", rd[3:0], f[3:0]);
            end
        end
    endtask
    task automatic t_jump();
        wr(sjle_pkg::REGF_BASE + 8'h0C, 32'h8000_1235);
        wr(sjle_pkg::PC_OFS, 32'h0000_0200);
        run({16'h0000, sjle_pkg::OP_JUMP, 5'h03});
        rdr(sjle_pkg::PC_OFS);
        check("delay slot pc", rd, 32'h0000_0202);
        rdr(sjle_pkg::CTRL_OFS);
        check("delay pending", rd[2], 1'b1);
        run(32'h0000_0000);
        rdr(sjle_pkg::PC_OFS);
        check("jump target", rd, 32'h0000_246A);
        rdr(8'h40);
        check("unmapped read", rd, 32'h0000_0000);
    endtask
    task automatic do_load(input logic [31:0] prefix_instruction, input logic [31:0] ins, input logic [7:0] ra,
                           input logic [31:0] ea, input logic [3:0] dly);
        int i;
        mem_delay <= dly;
        if (prefix_instruction != 32'h0) begin
            wr(sjle_pkg::PREFIX_OFS, prefix_instruction);
        end
        run(ins);
        for (i = 0; i < 40; i++) begin
            rdr(sjle_pkg::CTRL_OFS);
            if (rd[sjle_pkg::ST_BUSY_BIT] === 1'b0) break;
        end
        check("load done", rd[3:0], 4'h8);
        check("mem req idle", mem_req, 1'b0);
        rdr(sjle_pkg::LDADDR_OFS);
        check("load addr", rd, ea);
        rdr(sjle_pkg::REGF_BASE + (ra << 2));
        check("load data", rd, ea ^ MEM_PAT);
    endtask
    task automatic t_load();
        wr(sjle_pkg::REGF_BASE + 8'h10, 32'h0000_1003);
        wr(sjle_pkg::REGF_BASE + 8'h48, 32'h0000_2002);
        do_load(32'h0, {sjle_pkg::OP_WORD_LOAD, 5'h04, 5'h05}, 8'h05, 32'h1000, 4'h0);
        do_load(32'hFFE, {sjle_pkg::OP_WORD_LOAD, 5'h04, 5'h05}, 8'h05, 32'hFF8, 4'h7);
        do_load(32'h0, {sjle_pkg::OP_BASE_LOAD, 2'h2, 5'h1F, 5'h06}, 8'h06, 32'h207C, 4'h3);
        do_load(32'hFFF, {sjle_pkg::OP_BASE_LOAD, 2'h2, 5'h1F, 5'h06}, 8'h06, 32'h1FFC, 4'h1);
    endtask
    // ************************************************************
    // Main sequence and timeout
    // ************************************************************
    initial begin
        sys_rst_in = 1'b1;
        wb_req = '0;
        mem_delay = 4'h0;
        repeat (12) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        fork
            begin
                rdr(sjle_pkg::PC_OFS);
                check("pc after reset", rd, 32'h0000_0000);
                t_bit_skip();
                t_reg_skip();
                t_cond();
                t_jump();
                t_load();
            end
            begin
                repeat (60000) @(posedge sys_clk_in);
                err_total++;
            end
        join_any
        disable fork;
        give_verdict();
    end
endmodule
